// ==== design/ptwd_regs.svh ====
// Constants for the paging time word decoder.
// Assumes inclusion by bare name from design files.
`ifndef PTWD_REGS_SVH
`define PTWD_REGS_SVH
// ==========================================================
// Word kind codes
`define PTWD_KIND_DATE 3'h1
`define PTWD_KIND_TIME 3'h2
`define PTWD_KIND_SYS 3'h5
`define PTWD_SYS_TIME_A 4'h4
`define PTWD_SYS_TIME_B 4'h5
// ==========================================================
// Field positions
`define PTWD_MONTH_HI 13
`define PTWD_MONTH_LO 10
`define PTWD_DAY_HI 9
`define PTWD_DAY_LO 5
`define PTWD_YEAR_HI 4
`define PTWD_YEAR_LO 0
`define PTWD_CSEC_HI 13
`define PTWD_CSEC_LO 11
`define PTWD_MIN_HI 10
`define PTWD_MIN_LO 5
`define PTWD_HOUR_HI 4
`define PTWD_HOUR_LO 0
`define PTWD_FSEC_HI 13
`define PTWD_FSEC_LO 11
`define PTWD_DST_BIT 9
`define PTWD_ZONE_HI 8
`define PTWD_ZONE_LO 4
`define PTWD_SUB_HI 3
`define PTWD_SUB_LO 0
// ==========================================================
// Limits and conversions
`define PTWD_MONTH_MAX 4'hC
`define PTWD_DAY_MAX 5'h1F
`define PTWD_MIN_MAX 6'h3B
`define PTWD_HOUR_MAX 5'h17
`define PTWD_ZONE_RSVD 5'h10
`define PTWD_CSEC_HALF 8'h4B
`define PTWD_FSEC_STEP 12'h177
`define PTWD_FSEC_ROUND 12'h014
`define PTWD_FSEC_DIV 12'h028
`define PTWD_BASE_YEAR 12'h7EA
`define PTWD_LATCH_DELAY 2'h1
`endif

// ==== design/ptwd_pkg.sv ====
// Types shared by the paging time word decoder.
// Assumes no surroundings beyond the compiler.
package ptwd_pkg;
   // ==========================================================
   // Incoming block information word
   typedef struct packed {
      logic valid;
      logic [2:0] kind;
      logic [13:0] payload;
   } ptwd_word_t;
   // Date group
   typedef struct packed {
      logic [3:0] month;
      logic [4:0] day;
      logic [4:0] year;
      logic [11:0] full_year;
   } ptwd_date_t;
   // Time of day group; seconds in tenths
   typedef struct packed {
      logic [2:0] coarse;
      logic [5:0] minute;
      logic [4:0] hour;
      logic [9:0] sec_tenths;
   } ptwd_tod_t;
   // Zone group; offset in minutes, signed
   typedef struct packed {
      logic [2:0] fine;
      logic standard_time;
      logic [4:0] zone_code;
      logic zone_reserved;
      logic signed [10:0] zone_minutes;
   } ptwd_zone_t;
endpackage

// ==== design/ptwd_decoder.sv ====
// Paging time word decoder: date, time of day, fine seconds, zone.
// Assumes words arrive from same-clock frame logic, one per valid cycle.
`timescale 1ns/10ps
`default_nettype none
`include "ptwd_regs.svh"

module ptwd_decoder #(
   parameter logic [11:0] BASE_YEAR = `PTWD_BASE_YEAR
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire ptwd_pkg::ptwd_word_t word_in,
   output ptwd_pkg::ptwd_date_t date_out,
   output ptwd_pkg::ptwd_tod_t tod_out,
   output ptwd_pkg::ptwd_zone_t zone_out,
   output logic date_update,
   output logic tod_update,
   output logic zone_update
);

   // ==========================================================
   // Word classification
   logic is_date;
   logic is_tod;
   logic is_zone;
   logic [3:0] w_month;
   logic [4:0] w_day;
   logic [5:0] w_min;
   logic [4:0] w_hour;
   logic [3:0] w_sub;

   always_comb begin
      w_month = word_in.payload[`PTWD_MONTH_HI:`PTWD_MONTH_LO];
      w_day = word_in.payload[`PTWD_DAY_HI:`PTWD_DAY_LO];
      w_min = word_in.payload[`PTWD_MIN_HI:`PTWD_MIN_LO];
      w_hour = word_in.payload[`PTWD_HOUR_HI:`PTWD_HOUR_LO];
      w_sub = word_in.payload[`PTWD_SUB_HI:`PTWD_SUB_LO];
      // Out-of-range month, day, minute or hour words are dropped
      is_date = word_in.valid && word_in.kind == `PTWD_KIND_DATE
         && w_month != 4'h0 && w_month <= `PTWD_MONTH_MAX && w_day != 5'h0;
      is_tod = word_in.valid && word_in.kind == `PTWD_KIND_TIME
         && w_min <= `PTWD_MIN_MAX && w_hour <= `PTWD_HOUR_MAX;
      is_zone = word_in.valid && word_in.kind == `PTWD_KIND_SYS
         && (w_sub == `PTWD_SYS_TIME_A || w_sub == `PTWD_SYS_TIME_B);
   end

   // ==========================================================
   // Zone offset table, minutes from GMT for standard time
   function automatic logic signed [10:0] zone_offset(input logic [4:0] code);
      logic signed [10:0] m;
      m = 11'sd0;
      case (code)
         5'h0D: m = 11'sd210;
         5'h0E: m = 11'sd270;
         5'h0F: m = 11'sd330;
         5'h10: m = 11'sd0;
         5'h11: m = 11'sd345;
         5'h12: m = 11'sd390;
         5'h13: m = 11'sd570;
         5'h14: m = -11'sd210;
         default: begin
            if (code <= 5'h0C) begin
               m = 11'(code) * 11'sd60;
            end else begin
               m = (11'(code) - 11'sd32) * 11'sd60;
            end
         end
      endcase
      return m;
   endfunction

   // ==========================================================
   // Fine seconds to tenths, rounded; one step is 9.375 tenths
   function automatic logic [9:0] fine_to_tenths(input logic [2:0] fine);
      logic [11:0] scaled;
      scaled = (12'(fine) * `PTWD_FSEC_STEP + `PTWD_FSEC_ROUND) / `PTWD_FSEC_DIV;
      return scaled[9:0];
   endfunction

   // ==========================================================
   // Next-state computation
   ptwd_pkg::ptwd_date_t next_date;
   ptwd_pkg::ptwd_tod_t next_tod;
   ptwd_pkg::ptwd_zone_t next_zone;
   logic next_date_update;
   logic next_tod_update;
   logic next_zone_update;
   logic [9:0] fine_tenths;

   always_comb begin
      next_date = date_out;
      next_tod = tod_out;
      next_zone = zone_out;
      next_date_update = is_date;
      next_tod_update = is_tod;
      next_zone_update = is_zone;
      // Fine seconds of the held zone word
      fine_tenths = fine_to_tenths(zone_out.fine);
      if (is_date) begin
         next_date.month = w_month;
         next_date.day = w_day;
         next_date.year = word_in.payload[`PTWD_YEAR_HI:`PTWD_YEAR_LO];
         next_date.full_year = BASE_YEAR + 12'(word_in.payload[`PTWD_YEAR_HI:`PTWD_YEAR_LO]);
      end
      if (is_tod) begin
         next_tod.coarse = word_in.payload[`PTWD_CSEC_HI:`PTWD_CSEC_LO];
         next_tod.minute = w_min;
         next_tod.hour = w_hour;
         next_tod.sec_tenths = 10'(10'(next_tod.coarse) * 10'(`PTWD_CSEC_HALF))
            + fine_tenths;
      end
      if (is_zone) begin
         next_zone.fine = word_in.payload[`PTWD_FSEC_HI:`PTWD_FSEC_LO];
         next_zone.standard_time = word_in.payload[`PTWD_DST_BIT];
         next_zone.zone_code = word_in.payload[`PTWD_ZONE_HI:`PTWD_ZONE_LO];
         next_zone.zone_reserved = next_zone.zone_code == `PTWD_ZONE_RSVD;
         next_zone.zone_minutes = zone_offset(next_zone.zone_code);
         next_tod.sec_tenths = 10'(10'(tod_out.coarse) * 10'(`PTWD_CSEC_HALF))
            + fine_to_tenths(next_zone.fine);
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         date_out <= '0;
         tod_out <= '0;
         zone_out <= '0;
         date_update <= 1'b0;
         tod_update <= 1'b0;
         zone_update <= 1'b0;
      end else begin
         date_out <= next_date;
         tod_out <= next_tod;
         zone_out <= next_zone;
         date_update <= next_date_update;
         tod_update <= next_tod_update;
         zone_update <= next_zone_update;
      end
   end

   // ==========================================================
   // Checks
   a_date_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_date |=> date_update && date_out.month == $past(w_month)
         && date_out.day == $past(w_day))
      else $error("date fields not latched");
   a_year_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_date |=> date_out.year == $past(word_in.payload[`PTWD_YEAR_HI:`PTWD_YEAR_LO])
         && date_out.full_year == BASE_YEAR + 12'(date_out.year))
      else $error("year not latched");
   a_date_range: assert property (@(posedge core_clk) disable iff (!reset_n)
      date_update |-> date_out.month != 4'h0 && date_out.month <= `PTWD_MONTH_MAX
         && date_out.day != 5'h0)
      else $error("date out of range");
   a_tod_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_tod |=> tod_update && tod_out.minute == $past(w_min)
         && tod_out.hour == $past(w_hour))
      else $error("time fields not latched");
   a_tod_range: assert property (@(posedge core_clk) disable iff (!reset_n)
      tod_update |-> tod_out.minute <= `PTWD_MIN_MAX && tod_out.hour <= `PTWD_HOUR_MAX)
      else $error("time out of range");
   a_kind_refused: assert property (@(posedge core_clk) disable iff (!reset_n)
      word_in.valid && word_in.kind != `PTWD_KIND_DATE && word_in.kind != `PTWD_KIND_TIME
         && word_in.kind != `PTWD_KIND_SYS |=> !date_update && !tod_update && !zone_update)
      else $error("unknown word kind decoded");
   a_idle_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      !word_in.valid |=> !date_update && !tod_update && !zone_update
         && $stable(date_out) && $stable(tod_out) && $stable(zone_out))
      else $error("outputs changed without a word");
   a_sys_other_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      (word_in.valid && word_in.kind == `PTWD_KIND_SYS && !is_zone)
         |=> $stable(zone_out) && $stable(tod_out) && !zone_update)
      else $error("non-time system word changed zone");
   a_zone_fields: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_zone |=> zone_update
         && zone_out.fine == $past(word_in.payload[`PTWD_FSEC_HI:`PTWD_FSEC_LO])
         && zone_out.zone_code == $past(word_in.payload[`PTWD_ZONE_HI:`PTWD_ZONE_LO]))
      else $error("zone fields not latched");
   a_zone_reserved: assert property (@(posedge core_clk) disable iff (!reset_n)
      zone_update |-> zone_out.zone_reserved == (zone_out.zone_code == `PTWD_ZONE_RSVD))
      else $error("reserved zone flag wrong");
   a_zone_plus: assert property (@(posedge core_clk) disable iff (!reset_n)
      zone_update && zone_out.zone_code <= 5'h0C
         |-> zone_out.zone_minutes == 11'(zone_out.zone_code) * 11'sd60)
      else $error("whole hour zone wrong");
   a_zone_minus: assert property (@(posedge core_clk) disable iff (!reset_n)
      zone_update && zone_out.zone_code >= 5'h15
         |-> zone_out.zone_minutes < 11'sd0)
      else $error("negative zone wrong");
   a_dst_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
      is_zone |=> zone_out.standard_time == $past(word_in.payload[`PTWD_DST_BIT]))
      else $error("daylight flag wrong");
   a_strobe_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
      date_update |-> $past(is_date, `PTWD_LATCH_DELAY))
      else $error("spurious date strobe");
   a_coarse_only: assert property (@(posedge core_clk) disable iff (!reset_n)
      tod_update && zone_out.fine == 3'h0
         |-> tod_out.sec_tenths == 10'(tod_out.coarse) * `PTWD_CSEC_HALF)
      else $error("coarse seconds wrong");
   a_fine_add: assert property (@(posedge core_clk) disable iff (!reset_n)
      zone_update && zone_out.fine == 3'h7
         |-> tod_out.sec_tenths == 10'(tod_out.coarse) * `PTWD_CSEC_HALF + 10'h042)
      else $error("fine seconds not added");
   a_sec_range: assert property (@(posedge core_clk) disable iff (!reset_n)
      tod_update |-> tod_out.sec_tenths < 10'h258)
      else $error("seconds out of range");
   c_date: cover property (@(posedge core_clk) date_update);
   c_tod: cover property (@(posedge core_clk) tod_update);
   c_zone: cover property (@(posedge core_clk) zone_update && zone_out.zone_reserved);
   c_seq: cover property (@(posedge core_clk) tod_update ##[1:20] zone_update);

endmodule
`default_nettype wire

// ==== tb/ptwd_word_source.sv ====
// Upstream frame logic model: hands block information words to the decoder.
// Assumes the same clock as the decoder; the bench calls send.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Word source
module ptwd_word_source (
   input wire logic core_clk,
   output var ptwd_pkg::ptwd_word_t word_out
);
   initial word_out = '0;
   // One word, valid for one cycle, then the released bus shows inverted data
   task automatic send(input logic [2:0] kind, input logic [13:0] payload);
      @(posedge core_clk);
      #1 word_out = {1'b1, kind, payload};
      @(posedge core_clk);
      #1 word_out = {1'b0, ~kind, ~payload};
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_paging_time_word_decoder.sv ====
// Self-checking bench for the paging time word decoder.
// Assumes the design package and the word source model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_paging_time_word_decoder;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   ptwd_pkg::ptwd_word_t word_in;
   ptwd_pkg::ptwd_date_t date_out;
   ptwd_pkg::ptwd_tod_t tod_out;
   ptwd_pkg::ptwd_zone_t zone_out;
   logic date_update;
   logic tod_update;
   logic zone_update;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [13:0] bad_date [3] = '{{4'h0, 5'h01, 5'h00}, {4'hD, 5'h01, 5'h00}, {4'h1, 5'h00, 5'h00}};
   logic [13:0] bad_time [2] = '{{3'h0, 6'h3C, 5'h00}, {3'h0, 6'h00, 5'h18}};
   logic [2:0] bad_kind [5] = '{3'h0, 3'h3, 3'h4, 3'h6, 3'h7};
   // ==========================================================
   // Clock, instances
   always #20 core_clk = ~core_clk;
   ptwd_word_source i_src (.core_clk(core_clk), .word_out(word_in));
   ptwd_decoder i_dut (.core_clk(core_clk), .reset_n(reset_n), .word_in(word_in),
      .date_out(date_out), .tod_out(tod_out), .zone_out(zone_out),
      .date_update(date_update), .tod_update(tod_update), .zone_update(zone_update));
   // ==========================================================
   // Checking helpers
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic strobes(input logic [2:0] exp);
      check("strobes", {29'h0, date_update, tod_update, zone_update}, {29'h0, exp});
   endtask
   function automatic logic [10:0] zone_min(input int z);
      int m;
      case (z)
         13: m = 210;
         14: m = 270;
         15: m = 330;
         16: m = 0;
         17: m = 345;
         18: m = 390;
         19: m = 570;
         20: m = -210;
         default: m = (z < 13) ? z * 60 : -(32 - z) * 60;
      endcase
      return m[10:0];
   endfunction
   task automatic give_verdict();
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Timeout
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 1000) begin
         errors++;
         give_verdict();
      end
   end
   // ==========================================================
   // Tests
   initial begin
      repeat (3) @(posedge core_clk);
      #1 reset_n = 1'b1;
      check("date_rst", date_out, 32'h0);
      check("tod_rst", tod_out, 32'h0);
      check("zone_rst", zone_out, 32'h0);
      strobes(3'h0);
      i_src.send(3'h1, {4'hC, 5'h1F, 5'h05});
      strobes(3'h4);
      check("month", date_out.month, 32'hC);
      check("day", date_out.day, 32'h1F);
      check("year", date_out.year, 32'h5);
      check("full_year", date_out.full_year, 32'h7EF);
      @(posedge core_clk);
      #1 strobes(3'h0);
      i_src.send(3'h1, {4'h1, 5'h01, 5'h1F});
      check("full_year", date_out.full_year, 32'h809);
      foreach (bad_date[i]) begin
         i_src.send(3'h1, bad_date[i]);
         strobes(3'h0);
         check("month", date_out.month, 32'h1);
      end
      i_src.send(3'h2, {3'h7, 6'h3B, 5'h17});
      strobes(3'h2);
      check("coarse", tod_out.coarse, 32'h7);
      check("minute", tod_out.minute, 32'h3B);
      check("hour", tod_out.hour, 32'h17);
      check("sec_tenths", tod_out.sec_tenths, 32'd525);
      foreach (bad_time[i]) begin
         i_src.send(3'h2, bad_time[i]);
         strobes(3'h0);
      end
      foreach (bad_kind[i]) begin
         i_src.send(bad_kind[i], 14'h0A94);
         strobes(3'h0);
      end
      for (int i = 0; i < 32; i++) begin
         i_src.send(3'h5, {3'h3, i[1], i[0], i[4:0], 3'h2, i[2]});
         strobes(3'h1);
         check("zone_code", zone_out.zone_code, i);
         check("zone_min", {21'h0, zone_out.zone_minutes}, {21'h0, zone_min(i)});
         check("zone_rsvd", zone_out.zone_reserved, i == 16);
         check("standard", zone_out.standard_time, i[0]);
         check("fine", zone_out.fine, 32'h3);
      end
      check("sec_tenths", tod_out.sec_tenths, 32'd553);
      i_src.send(3'h5, {3'h7, 1'b0, 1'b1, 5'h01, 4'h6});
      strobes(3'h0);
      check("zone_code", zone_out.zone_code, 32'h1F);
      check("fine", zone_out.fine, 32'h3);
      check("sec_tenths", tod_out.sec_tenths, 32'd553);
      i_src.send(3'h2, {3'h2, 6'h00, 5'h00});
      check("sec_tenths", tod_out.sec_tenths, 32'd178);
      i_src.send(3'h5, {3'h7, 1'b0, 1'b0, 5'h00, 4'h4});
      check("sec_tenths", tod_out.sec_tenths, 32'd216);
      // Mid-run reset clears every group, then decoding resumes
      @(posedge core_clk);
      #1 reset_n = 1'b0;
      @(posedge core_clk);
      #1 reset_n = 1'b1;
      check("date_rst", date_out, 32'h0);
      check("tod_rst", tod_out, 32'h0);
      check("zone_rst", zone_out, 32'h0);
      strobes(3'h0);
      i_src.send(3'h2, {3'h1, 6'h01, 5'h02});
      strobes(3'h2);
      check("sec_tenths", tod_out.sec_tenths, 32'h4B);
      check("minute", tod_out.minute, 32'h1);
      check("hour", tod_out.hour, 32'h2);
      give_verdict();
   end
endmodule
`default_nettype wire
